/* design/readout_pkg.sv */
/*
 * shared constants and types of the linear array readout sequencer.
 * assumes a single 10 MHz system clock; sensor clock and start pulse are sampled on it.
 */
package readout_pkg;
    localparam int NUM_PIXELS         = 64;
    localparam int PIX_W              = 6;
    localparam int LEVEL_W            = 10;
    localparam int STAMP_W            = 24;
    localparam int FIFO_DEPTH         = 16;
    localparam int CLK_PERIOD_NS      = 100;
    localparam int SENSOR_MIN_PER_NS  = 200;
    localparam int SENSOR_MIN_CYC     = (SENSOR_MIN_PER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MAX_INT_TIME_MS    = 100;
    localparam int MAX_INT_CYC        = MAX_INT_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [PIX_W-1:0] FIRST_PIXEL = 6'h00;
    localparam logic [PIX_W-1:0] LAST_PIXEL  = 6'h3f;
    localparam int WORD_W             = 2 + PIX_W + LEVEL_W + STAMP_W;

    typedef enum logic {ST_IDLE, ST_READ} seq_state_e;
endpackage

/* design/stamp_ram.sv */
/*
 * small single-clock memory: one write port, one read port, read data registered.
 * assumes read and write addresses are in range.
 */
`timescale 1ns/1ps
module stamp_ram #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic             clk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_en,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    if (DEPTH > (1 << AW)) begin
        $error("stamp_ram: depth exceeds address width");
    end

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

/* design/word_fifo.sv */
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes depth is a power of two; out_data is the head entry.
 */
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 42,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
        $error("word_fifo: depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
    logic             push, pop;
    logic             head_valid_q, head_valid_d;
    logic [WIDTH-1:0] head_q, head_d;

    always_comb begin
        in_ready     = (wr_q - rd_q) != (AW+1)'(DEPTH);
        push         = in_valid & in_ready;
        pop          = head_valid_q & out_ready;
        wr_d         = push ? wr_q + 1'b1 : wr_q;
        rd_d         = pop ? rd_q + 1'b1 : rd_q;
        head_valid_d = wr_d != rd_d;
        // a word landing in the new head slot this edge bypasses the array
        head_d       = (push && wr_q[AW-1:0] == rd_d[AW-1:0]) ? in_data : mem[rd_d[AW-1:0]];
    end

    assign out_valid = head_valid_q;
    assign out_data  = head_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_q         <= '0;
            rd_q         <= '0;
            head_valid_q <= 1'b0;
            head_q       <= '0;
        end else begin
            wr_q         <= wr_d;
            rd_q         <= rd_d;
            head_valid_q <= head_valid_d;
            head_q       <= head_d;
        end
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule

/* design/linear_array_readout_sequencer.sv */
/*
 * pixel sequencer of a 64-pixel linear light-sensor array: start pulse and sensor
 * clock in, per-pixel hold/reset switch control, held level out with output enable,
 * and a buffered digital stream of each pixel with its integration time.
 * assumes start_integration, sensor_clock and pixel_level are synchronous to clk.
 */
`timescale 1ns/1ps
module linear_array_readout_sequencer
    import readout_pkg::*;
#(
    parameter int NPIX      = readout_pkg::NUM_PIXELS,
    parameter int LVL_W     = readout_pkg::LEVEL_W,
    parameter int FDEPTH    = readout_pkg::FIFO_DEPTH,
    parameter int MAX_INT   = readout_pkg::MAX_INT_CYC
) (
    input  wire logic                              clk,
    input  wire logic                              srst,
    input  wire logic                              start_integration,
    input  wire logic                              sensor_clock,
    input  wire logic [LVL_W-1:0]                  pixel_level,
    output logic      [readout_pkg::PIX_W-1:0]     pixel_select,
    output logic                                   sample_hold_switch,
    output logic                                   integrator_reset_switch,
    output logic      [LVL_W-1:0]                  analog_pixel_output,
    output logic                                   analog_pixel_output_oe,
    output logic                                   readout_active,
    output logic                                   clock_too_fast,
    output logic                                   stream_overrun,
    output logic                                   pix_valid,
    input  wire logic                              pix_ready,
    output logic      [readout_pkg::WORD_W-1:0]    pix_data
);
    import readout_pkg::*;

    if (NPIX != NUM_PIXELS || LVL_W != LEVEL_W) begin
        $error("sequencer: pixel count and level width are fixed");
    end
    if (MAX_INT < 1 || MAX_INT >= (1 << STAMP_W)) begin
        $error("sequencer: MAX_INT out of stamp range");
    end

    // edge detection: inputs are already synchronous
    logic sclk_q;
    logic rise;
    logic start_ok;
    logic adv;
    assign rise = sensor_clock & ~sclk_q;

    seq_state_e       state_q, state_d;
    logic [PIX_W-1:0] idx_q, idx_d;
    logic             hold_q, hold_d;
    logic             rst_q, rst_d;
    logic             oe_q, oe_d;
    logic [LVL_W-1:0] ao_q, ao_d;
    logic             cap_d, cap_q;

    always_comb begin
        // start honoured when idle or on the n+1 clock
        start_ok = rise & start_integration & (state_q == ST_IDLE || idx_q == LAST_PIXEL);
        adv      = rise & (state_q == ST_READ) & ~start_ok;
        state_d  = state_q;
        idx_d    = idx_q;
        hold_d   = hold_q;
        rst_d    = rst_q;
        oe_d     = oe_q;
        ao_d     = ao_q;
        cap_d    = 1'b0;
        if (start_ok) begin
            // pixel 1 selected and held first
            state_d = ST_READ;
            idx_d   = FIRST_PIXEL;
            hold_d  = 1'b1;
            rst_d   = 1'b0;
            oe_d    = 1'b1;
            ao_d    = pixel_level;
            cap_d   = 1'b1;
        end else if (adv) begin
            if (idx_q == LAST_PIXEL) begin
                state_d = ST_IDLE;
                hold_d  = 1'b0;
                rst_d   = 1'b0;
                oe_d    = 1'b0;
            end else begin
                // release reset, move on to next pixel
                idx_d  = idx_q + 1'b1;
                hold_d = 1'b1;
                rst_d  = 1'b0;
                ao_d   = pixel_level;
                cap_d  = 1'b1;
            end
        end else if (state_q == ST_READ && hold_q && !rst_q) begin
            // clear integrator only after the hold is in place
            rst_d = 1'b1;
        end
    end

    // sequencer steps only on rising sensor clock
    always_ff @(posedge clk) begin
        if (srst) begin
            sclk_q  <= 1'b0;
            state_q <= ST_IDLE;
            idx_q   <= FIRST_PIXEL;
            hold_q  <= 1'b0;
            rst_q   <= 1'b0;
            oe_q    <= 1'b0;
            ao_q    <= '0;
            cap_q   <= 1'b0;
        end else begin
            sclk_q  <= sensor_clock;
            state_q <= state_d;
            idx_q   <= idx_d;
            hold_q  <= hold_d;
            rst_q   <= rst_d;
            oe_q    <= oe_d;
            ao_q    <= ao_d;
            cap_q   <= cap_d;
        end
    end

    assign pixel_select            = idx_q;
    assign sample_hold_switch      = hold_q;
    assign integrator_reset_switch = rst_q;
    assign analog_pixel_output     = ao_q;
    assign analog_pixel_output_oe  = oe_q;
    assign readout_active          = state_q == ST_READ;

    // rising edges closer than the sensor's minimum period
    logic [2:0] gap_q, gap_d;
    logic       fast_q, fast_d;

    always_comb begin
        gap_d  = rise ? 3'h1 : (gap_q == 3'h7 ? gap_q : gap_q + 1'b1);
        fast_d = fast_q | (rise & (gap_q < 3'(SENSOR_MIN_CYC)));
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            gap_q  <= 3'h7;
            fast_q <= 1'b0;
        end else begin
            gap_q  <= gap_d;
            fast_q <= fast_d;
        end
    end

    assign clock_too_fast = fast_q;

    // integration time per pixel: free-running stamp, last read kept per pixel
    logic [STAMP_W-1:0] now_q, now_d;
    logic [STAMP_W-1:0] stamp_rd;
    logic [NPIX-1:0]    seen_q, seen_d;
    logic [STAMP_W-1:0] int_time;
    logic               int_valid;
    logic               int_over;

    stamp_ram #(
        .WIDTH (STAMP_W),
        .DEPTH (NPIX),
        .AW    (PIX_W)
    ) u_stamps (
        .clk     (clk),
        .wr_en   (cap_q),
        .wr_addr (idx_q),
        .wr_data (now_q),
        .rd_en   (cap_d),
        .rd_addr (idx_d),
        .rd_data (stamp_rd)
    );

    always_comb begin
        now_d     = now_q + 1'b1;
        // interval between two reads of the same pixel
        int_time  = now_q - stamp_rd;
        int_valid = seen_q[idx_q];
        int_over  = int_valid & (int_time > STAMP_W'(MAX_INT));
        seen_d    = seen_q;
        if (cap_q) begin
            seen_d[idx_q] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            now_q  <= '0;
            seen_q <= '0;
        end else begin
            now_q  <= now_d;
            seen_q <= seen_d;
        end
    end

    // pending word waits for fifo space; a second capture while waiting is an overrun
    logic              pend_valid_q, pend_valid_d;
    logic [WORD_W-1:0] pend_q, pend_d;
    logic              ovr_q, ovr_d;
    logic              fifo_in_ready;

    always_comb begin
        pend_valid_d = pend_valid_q & ~fifo_in_ready;
        pend_d       = pend_q;
        ovr_d        = ovr_q;
        if (cap_q) begin
            ovr_d        = ovr_q | (pend_valid_q & ~fifo_in_ready);
            pend_valid_d = 1'b1;
            pend_d       = {int_valid, int_over, idx_q, ao_q, int_valid ? int_time : '0};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pend_valid_q <= 1'b0;
            pend_q       <= '0;
            ovr_q        <= 1'b0;
        end else begin
            pend_valid_q <= pend_valid_d;
            pend_q       <= pend_d;
            ovr_q        <= ovr_d;
        end
    end

    assign stream_overrun = ovr_q;

    word_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FDEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (pend_valid_q),
        .in_ready  (fifo_in_ready),
        .in_data   (pend_q),
        .out_valid (pix_valid),
        .out_ready (pix_ready),
        .out_data  (pix_data)
    );

    // pixels shown since the last start, for checking the readout length
    logic [6:0] shown_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            shown_q <= '0;
        end else if (start_ok) begin
            shown_q <= 7'h01;
        end else if (adv && idx_q != LAST_PIXEL) begin
            shown_q <= shown_q + 1'b1;
        end
    end

    sequence s_start_quiet;
        start_ok ##1 !rise;
    endsequence

    sequence s_hold_then_reset;
        (pixel_select == FIRST_PIXEL && sample_hold_switch && !integrator_reset_switch) ##1 integrator_reset_switch;
    endsequence

    a_first_pixel_hold: assert property (@(posedge clk) disable iff (srst)
        s_start_quiet |-> s_hold_then_reset)
        else $error("first pixel not held then reset");

    a_next_pixel_step: assert property (@(posedge clk) disable iff (srst)
        (adv && idx_q != LAST_PIXEL) |=> (pixel_select == $past(idx_q) + 1'b1) && !integrator_reset_switch
            && sample_hold_switch)
        else $error("next pixel not stepped with reset released");

    a_readout_length: assert property (@(posedge clk) disable iff (srst)
        $fell(analog_pixel_output_oe) |-> shown_q == 7'h40 && $past(pixel_select) == LAST_PIXEL)
        else $error("readout did not present 64 pixels");

    a_output_release: assert property (@(posedge clk) disable iff (srst)
        (adv && idx_q == LAST_PIXEL) |=> !analog_pixel_output_oe && !readout_active)
        else $error("output not released at n+1 edge");

    a_early_start_ignored: assert property (@(posedge clk) disable iff (srst)
        (rise && start_integration && readout_active && idx_q != LAST_PIXEL)
            |=> pixel_select == $past(idx_q) + 1'b1)
        else $error("early start pulse restarted the readout");

    a_int_time_stamp: assert property (@(posedge clk) disable iff (srst)
        (cap_q && seen_q[idx_q]) |=> pend_valid_q && pend_q[STAMP_W-1:0] == $past(now_q) - $past(stamp_rd))
        else $error("integration time not the read interval");

    a_output_steady: assert property (@(posedge clk) disable iff (srst)
        !rise |=> $stable(analog_pixel_output) && $stable(analog_pixel_output_oe))
        else $error("pixel output changed within a sensor period");

    a_edge_only_step: assert property (@(posedge clk) disable iff (srst)
        !rise |=> $stable(pixel_select) && $stable(readout_active))
        else $error("pixel advanced without a rising sensor clock");
endmodule

/* dv/sensor_controller_model.sv */
/*
 * behavioural model of the external controller: sensor clock, start pulse, pixel level.
 * assumes it is stepped by the testbench, one sensor clock rise per call of rise().
 */
`timescale 1ns/1ps
module sensor_controller_model (
    input  wire logic                       clk,
    output logic                            sensor_clock,
    output logic                            start_integration,
    output logic [readout_pkg::LEVEL_W-1:0] pixel_level
);
    import readout_pkg::*;

    initial begin
        sensor_clock      = 1'b0;
        start_integration = 1'b0;
        pixel_level       = '0;
    end

    // three clk per sensor period: 300 ns, slower than the 5 MHz ceiling
    // fixed clock spacing
    // level held for capture
    // two idle edges first, so the caller can look right after the capturing edge
    task automatic rise(input logic s, input logic [LEVEL_W-1:0] l);
        @(posedge clk);
        @(posedge clk);
        sensor_clock      <= 1'b1;
        start_integration <= s;
        pixel_level       <= l;
        @(posedge clk);
        sensor_clock      <= 1'b0;
        start_integration <= 1'b0;
        // stale level inverted so a late capture shows up
        pixel_level       <= ~l;
        #1;
    endtask
endmodule

/* dv/linear_array_readout_sequencer_tb_top.sv */
/*
 * self-checking testbench of the readout sequencer: flush, readouts, restart, stream.
 * assumes the controller model in sensor_controller_model and a 10 MHz clk.
 */
`timescale 1ns/1ps
module linear_array_readout_sequencer_tb_top;
    import readout_pkg::*;

    logic               clk = 1'b0;
    logic               srst = 1'b1;
    logic               pix_ready = 1'b1;
    logic               start_integration;
    logic               sensor_clock;
    logic [LEVEL_W-1:0] pixel_level;
    logic [PIX_W-1:0]   pixel_select;
    logic               sample_hold_switch;
    logic               integrator_reset_switch;
    logic [LEVEL_W-1:0] analog_pixel_output;
    logic               analog_pixel_output_oe;
    logic               readout_active;
    logic               clock_too_fast;
    logic               stream_overrun;
    logic               pix_valid;
    logic [WORD_W-1:0]  pix_data;
    int                 err_total = 0;
    int                 checks = 0;
    int                 cycles = 0;

    always #50 clk = ~clk;

    sensor_controller_model sensor_controller_model_inst (
        .clk               (clk),
        .sensor_clock      (sensor_clock),
        .start_integration (start_integration),
        .pixel_level       (pixel_level)
    );

    linear_array_readout_sequencer #(.MAX_INT(1000)) linear_array_readout_sequencer_inst (
        .clk                     (clk),
        .srst                    (srst),
        .start_integration       (start_integration),
        .sensor_clock            (sensor_clock),
        .pixel_level             (pixel_level),
        .pixel_select            (pixel_select),
        .sample_hold_switch      (sample_hold_switch),
        .integrator_reset_switch (integrator_reset_switch),
        .analog_pixel_output     (analog_pixel_output),
        .analog_pixel_output_oe  (analog_pixel_output_oe),
        .readout_active          (readout_active),
        .clock_too_fast          (clock_too_fast),
        .stream_overrun          (stream_overrun),
        .pix_valid               (pix_valid),
        .pix_ready               (pix_ready),
        .pix_data                (pix_data)
    );

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one sensor rise, outputs looked at just after the edge that takes it
    task automatic step(input logic s, input int k);
        logic [LEVEL_W-1:0] l;
        logic [PIX_W-1:0]   e;
        l = {4'ha, k[5:0]};
        e = k[5:0];
        sensor_controller_model_inst.rise(s, l);
        if (k == 64 && !s) begin
            chk("oe", 1'b0, analog_pixel_output_oe);
            chk("active", 1'b0, readout_active);
            chk("hold", 1'b0, sample_hold_switch);
        end else begin
            chk("select", e, pixel_select);
            chk("level", l, analog_pixel_output);
            chk("hold", 1'b1, sample_hold_switch);
            chk("reset_sw", 1'b0, integrator_reset_switch);
            chk("oe", 1'b1, analog_pixel_output_oe);
        end
    endtask

    task automatic flush_run;
        step(1'b1, 0);
        @(posedge clk);
        #1;
        chk("reset_sw", 1'b1, integrator_reset_switch);
        for (int k = 1; k <= 64; k++) begin
            step(1'b0, k);
        end
    endtask

    // mid-readout start ignored, start on the n+1 rise restarts
    task automatic readout_a;
        step(1'b1, 0);
        for (int k = 1; k < 64; k++) begin
            step(k == 10, k);
        end
        // restart on the n+1 rise: shortest integration
        step(1'b1, 64);
    endtask

    // stream stalled: fifo fills, overrun, then drained in order
    task automatic readout_b;
        logic [WORD_W-1:0] w;
        int                n;
        fork
            step(1'b0, 1);
            begin
                @(posedge clk);
                pix_ready <= 1'b0;
            end
        join
        for (int k = 2; k <= 64; k++) begin
            step(1'b0, k);
        end
        chk("overrun", 1'b1, stream_overrun);
        chk("valid_full", 1'b1, pix_valid);
        chk("too_fast", 1'b0, clock_too_fast);
        for (int p = 0; p < FIFO_DEPTH; p++) begin
            // 64 rises of 3 clk between two reads of one pixel
            w = {1'b1, 1'b0, p[5:0], 4'ha, p[5:0], 24'hc0};
            chk("word", w, pix_data);
            @(posedge clk);
            pix_ready <= 1'b1;
            @(posedge clk);
            pix_ready <= 1'b0;
            #1;
        end
        @(posedge clk);
        pix_ready <= 1'b1;
        n = 0;
        while (pix_valid !== 1'b0 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("valid_empty", 1'b0, pix_valid);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk("oe_reset", 1'b0, analog_pixel_output_oe);
        chk("active_reset", 1'b0, readout_active);
        chk("valid_reset", 1'b0, pix_valid);
        flush_run();
        readout_a();
        readout_b();
        close_out();
    end
endmodule
